// ===== mcgp_pkg.sv
// Purpose: shared constants and carriers for the general-purpose port block
// Assumes: 16-bit register port, word offsets on a 4-bit address
// Notes:   offsets and field positions are named once here
package mcgp_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned AXIS_PINS = 4;
  localparam int unsigned SHARED_PINS = 6;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_MODE   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_REG_SELECT  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_WRITE_BUF   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_AXIS_PORT   = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_AXIS_ENV    = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_SHARED_DIR  = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_SHARED_DATA = 4'h6;

  // register-selection code that routes the write buffer to the axis port
  localparam logic [7:0] SEL_AXIS_PORT = 8'h01;

  // field positions
  localparam int unsigned CTRL_OUT_LEVEL_BIT = 4;
  localparam int unsigned ENV_DIR_LSB        = 8;
  localparam int unsigned ENV_FUNC_SEL_BIT   = 13;
  localparam int unsigned PORT_MUB_BIT       = 4;
  localparam int unsigned PORT_MFH_BIT       = 5;

  // reset values
  localparam logic [DATA_W-1:0]      RST_AXIS_ENV   = 16'h0000;
  localparam logic [7:0]             RST_REG_SELECT = 8'h00;
  localparam logic [AXIS_PINS-1:0]   RST_AXIS_OUT   = 4'h0;
  localparam logic [SHARED_PINS-1:0] RST_SHARED_DIR = 6'h3f;
  localparam logic [SHARED_PINS-1:0] RST_SHARED_OUT = 6'h00;
  localparam logic                   RST_GEN_OUT    = 1'b0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } mcgp_req_t;

endpackage

// ===== mcgp_pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to mclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module mcgp_pin_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } mcgp_sync_st_t;

  mcgp_sync_st_t st_q;
  mcgp_sync_st_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.s1   = pin_in;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    // a bit moves only once stages two and three agree
    st_d.filt = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.filt);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.filt;

endmodule

// ===== mcgp_pin_drive.sv
// Purpose: registered output and enable for a bank of two-way pins
// Assumes: dir bit 1 means input, 0 means output
// Notes:   reset leaves every pin undriven
`timescale 1ns/10ps
module mcgp_pin_drive #(
  parameter int unsigned W = 4
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] dir_in,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe
);

  typedef struct packed {
    logic [W-1:0] o;
    logic [W-1:0] oe;
  } mcgp_drv_st_t;

  mcgp_drv_st_t st_q;
  mcgp_drv_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.o  = level & ~dir_in;
    st_d.oe = ~dir_in;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_o  = st_q.o;
  assign pin_oe = st_q.oe;

endmodule

// ===== mcgp_ports.sv
// Purpose: general-purpose port logic of a stepper pulse controller
// Assumes: one mclk domain, synchronous active-low reset
// Notes:   pin levels read back through the three-stage synchroniser
`timescale 1ns/10ps
module mcgp_ports
  import mcgp_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire mcgp_req_t              reg_req,
  output logic      [DATA_W-1:0]      reg_rdata,
  input  wire logic [AXIS_PINS-1:0]   excitation_phase_outputs,
  input  wire logic                   exc_unipolar_pin,
  input  wire logic                   exc_fullhalf_pin,
  input  wire logic [AXIS_PINS-1:0]   axis_io_pins_i,
  output logic      [AXIS_PINS-1:0]   axis_io_pins_o,
  output logic      [AXIS_PINS-1:0]   axis_io_pins_oe,
  input  wire logic [SHARED_PINS-1:0] shared_io_pins_i,
  output logic      [SHARED_PINS-1:0] shared_io_pins_o,
  output logic      [SHARED_PINS-1:0] shared_io_pins_oe,
  output logic                        general_output_pin
);

  typedef struct packed {
    logic                   gen_out;
    logic [DATA_W-1:0]      env;
    logic [7:0]             reg_sel;
    logic [AXIS_PINS-1:0]   axis_out;
    logic [SHARED_PINS-1:0] shared_dir;
    logic [SHARED_PINS-1:0] shared_out;
    logic [DATA_W-1:0]      rdata;
  } mcgp_st_t;

  mcgp_st_t st_q;
  mcgp_st_t st_d;

  logic [AXIS_PINS-1:0]   axis_level;
  logic [SHARED_PINS-1:0] shared_level;
  logic [1:0]             exc_level;
  logic                   func_gpio;
  logic [AXIS_PINS-1:0]   axis_dir;
  logic [AXIS_PINS-1:0]   axis_drive;
  logic                   wr_buf_strobe;

  function automatic logic hit(input mcgp_req_t r, input logic [ADDR_W-1:0] ofs);
    return r.addr == ofs;
  endfunction

  mcgp_pin_sync #(.W(AXIS_PINS)) u_axis_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin_in (axis_io_pins_i),
    .level  (axis_level)
  );

  // one shared bank regardless of axis count
  mcgp_pin_sync #(.W(SHARED_PINS)) u_shared_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin_in (shared_io_pins_i),
    .level  (shared_level)
  );

  mcgp_pin_sync #(.W(2)) u_exc_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin_in ({exc_fullhalf_pin, exc_unipolar_pin}),
    .level  (exc_level)
  );

  assign func_gpio = st_q.env[ENV_FUNC_SEL_BIT];
  // phase mode drives all four pins; gpio mode honours direction bits
  assign axis_dir   = func_gpio ? st_q.env[ENV_DIR_LSB +: AXIS_PINS] : '0;
  assign axis_drive = func_gpio ? st_q.axis_out : excitation_phase_outputs;

  mcgp_pin_drive #(.W(AXIS_PINS)) u_axis_drive (
    .mclk   (mclk),
    .resetn (resetn),
    .dir_in (axis_dir),
    .level  (axis_drive),
    .pin_o  (axis_io_pins_o),
    .pin_oe (axis_io_pins_oe)
  );

  mcgp_pin_drive #(.W(SHARED_PINS)) u_shared_drive (
    .mclk   (mclk),
    .resetn (resetn),
    .dir_in (st_q.shared_dir),
    .level  (st_q.shared_out),
    .pin_o  (shared_io_pins_o),
    .pin_oe (shared_io_pins_oe)
  );

  assign wr_buf_strobe = reg_req.wr && hit(reg_req, OFS_WRITE_BUF);

  always_comb begin
    st_d       = st_q;
    st_d.rdata = '0;
    if (reg_req.wr) begin
      if (hit(reg_req, OFS_CTRL_MODE)) begin
        st_d.gen_out = reg_req.wdata[CTRL_OUT_LEVEL_BIT];
      end
      if (hit(reg_req, OFS_REG_SELECT)) begin
        st_d.reg_sel = reg_req.wdata[7:0];
      end
      if (hit(reg_req, OFS_AXIS_ENV)) begin
        st_d.env = reg_req.wdata;
      end
      if (hit(reg_req, OFS_SHARED_DIR)) begin
        st_d.shared_dir = reg_req.wdata[SHARED_PINS-1:0];
      end
      if (hit(reg_req, OFS_SHARED_DATA)) begin
        st_d.shared_out = reg_req.wdata[SHARED_PINS-1:0];
      end
    end
    // axis levels land only through the write buffer once selected
    if (wr_buf_strobe && st_q.reg_sel == SEL_AXIS_PORT) begin
      st_d.axis_out = reg_req.wdata[AXIS_PINS-1:0];
    end
    if (reg_req.rd) begin
      if (hit(reg_req, OFS_AXIS_PORT)) begin
        st_d.rdata[AXIS_PINS-1:0] = axis_level;
        st_d.rdata[PORT_MUB_BIT]  = exc_level[0];
        st_d.rdata[PORT_MFH_BIT]  = exc_level[1];
      end
      if (hit(reg_req, OFS_SHARED_DATA)) begin
        st_d.rdata[SHARED_PINS-1:0] = shared_level;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q.gen_out    <= RST_GEN_OUT;
      st_q.env        <= RST_AXIS_ENV;
      st_q.reg_sel    <= RST_REG_SELECT;
      st_q.axis_out   <= RST_AXIS_OUT;
      st_q.shared_dir <= RST_SHARED_DIR;
      st_q.shared_out <= RST_SHARED_OUT;
      st_q.rdata      <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata          = st_q.rdata;
  assign general_output_pin = st_q.gen_out;

endmodule

// ===== mcgp_ports_assertions.sv
// Purpose: port timing checks
// Assumes: one mclk domain
// Notes:   bound to the top module
`timescale 1ns/10ps
module mcgp_ports_chk
  import mcgp_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   resetn,
  input wire mcgp_req_t              reg_req,
  input wire logic [DATA_W-1:0]      reg_rdata,
  input wire logic [AXIS_PINS-1:0]   axis_io_pins_o,
  input wire logic [AXIS_PINS-1:0]   axis_io_pins_oe,
  input wire logic [SHARED_PINS-1:0] shared_io_pins_o,
  input wire logic [SHARED_PINS-1:0] shared_io_pins_oe,
  input wire logic                   general_output_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_gen_level: assert property (reg_req.wr && reg_req.addr == OFS_CTRL_MODE |->
    ##2 general_output_pin == $past(reg_req.wdata[CTRL_OUT_LEVEL_BIT], 2)) else $error("gen");
  chk_shared_dir: assert property (reg_req.wr && reg_req.addr == OFS_SHARED_DIR |->
    ##2 shared_io_pins_oe == ~$past(reg_req.wdata[5:0], 2)) else $error("sdir");
  chk_axis_env: assert property (reg_req.wr && reg_req.addr == OFS_AXIS_ENV |-> ##2
    axis_io_pins_oe == ($past(reg_req.wdata[ENV_FUNC_SEL_BIT], 2)
    ? ~$past(reg_req.wdata[ENV_DIR_LSB +: AXIS_PINS], 2) : 4'hf)) else $error("env");
  chk_reset_dir: assert property ($rose(resetn) |-> shared_io_pins_oe == 6'h00
    ##[1:2] axis_io_pins_oe == 4'hf) else $error("rst");
  chk_rd_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 16'h0000) else $error("idle");
  chk_rd_upper: assert property ($past(reg_req.rd) |-> reg_rdata[15:6] == 10'h000)
    else $error("upper");
  chk_axis_gate: assert property ((axis_io_pins_o & ~axis_io_pins_oe) == 4'h0)
    else $error("agate");
  chk_shared_gate: assert property ((shared_io_pins_o & ~shared_io_pins_oe) == 6'h00)
    else $error("sgate");
  cover property (reg_req.rd ##1 reg_rdata != 16'h0000);
  cover property ($rose(general_output_pin));
  cover property (axis_io_pins_oe == 4'h5);
endmodule
bind mcgp_ports mcgp_ports_chk i_mcgp_ports_chk (.mclk, .resetn, .reg_req, .reg_rdata,
  .axis_io_pins_o, .axis_io_pins_oe, .shared_io_pins_o, .shared_io_pins_oe,
  .general_output_pin);

// ===== mcgp_pin_world.sv
// Purpose: board-side pin model
// Assumes: board drivers yield where the chip drives
// Notes:   no contention modelled
`timescale 1ns/10ps
module mcgp_pin_world (
  input  wire logic [3:0] ax_o,
  input  wire logic [3:0] ax_oe,
  input  wire logic [3:0] ax_ext,
  input  wire logic [5:0] sh_o,
  input  wire logic [5:0] sh_oe,
  input  wire logic [5:0] sh_ext,
  output logic      [3:0] ax_pin,
  output logic      [5:0] sh_pin
);
  assign ax_pin = (ax_o & ax_oe) | (ax_ext & ~ax_oe);
  assign sh_pin = (sh_o & sh_oe) | (sh_ext & ~sh_oe);
endmodule

// ===== mcgp_ports_bench.sv
// Purpose: bench for the general ports
// Assumes: 250 MHz mclk
// Notes:   pins closed through the board model
`timescale 1ns/10ps
module mcgp_ports_bench;
  import mcgp_pkg::*;
  logic      mclk = 0, resetn = 0, unip = 1, fh = 0, gen;
  mcgp_req_t req = '0;
  logic [15:0] rdata;
  logic [3:0]  ph = 4'h5, ax_o, ax_oe, ax_pin;
  logic [5:0]  sh_o, sh_oe, sh_pin;
  // board holds shared pin 2 high so input readback is not all zero
  logic [5:0]  sh_ext = 6'h04;
  int          fails = 0, cmp_count = 0, cyc = 0;
  always #2 mclk = ~mclk;
  mcgp_ports i_mcgp_ports (.mclk(mclk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata),
    .excitation_phase_outputs(ph), .exc_unipolar_pin(unip), .exc_fullhalf_pin(fh),
    .axis_io_pins_i(ax_pin), .axis_io_pins_o(ax_o), .axis_io_pins_oe(ax_oe),
    .shared_io_pins_i(sh_pin), .shared_io_pins_o(sh_o), .shared_io_pins_oe(sh_oe),
    .general_output_pin(gen));
  mcgp_pin_world i_mcgp_pin_world (.ax_o(ax_o), .ax_oe(ax_oe), .ax_ext(4'ha), .sh_o(sh_o),
    .sh_oe(sh_oe), .sh_ext(sh_ext), .ax_pin(ax_pin), .sh_pin(sh_pin));
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      close_out;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // covers the synchroniser and the pin drive output register stage
  task automatic settle;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  task automatic t_gen;
    wr(OFS_CTRL_MODE, 16'h0010);
    settle;
    chk({15'h0, gen}, 16'h0001);
    wr(OFS_CTRL_MODE, 16'h00ef);
    settle;
    chk({15'h0, gen}, 16'h0000);
  endtask
  task automatic t_phase;
    chk({12'h0, ax_oe}, 16'h000f);
    chk({10'h0, sh_oe}, 16'h0000);
    chk({12'h0, ax_o}, 16'h0005);
    @(posedge mclk);
    ph <= 4'ha;
    settle;
    chk({12'h0, ax_o}, 16'h000a);
    rd(OFS_SHARED_DATA, 16'h0004);
  endtask
  task automatic t_axis;
    wr(OFS_AXIS_ENV, 16'h2a00);
    wr(OFS_REG_SELECT, {8'h00, SEL_AXIS_PORT});
    wr(OFS_WRITE_BUF, 16'hff0f);
    settle;
    chk({8'h0, ax_oe, ax_o}, 16'h0055);
    // buffer write without the port selected, and a direct port write, must not land
    wr(OFS_REG_SELECT, 16'h0000);
    wr(OFS_WRITE_BUF, 16'h0000);
    wr(OFS_AXIS_PORT, 16'h0000);
    settle;
    chk({8'h0, ax_oe, ax_o}, 16'h0055);
    rd(OFS_AXIS_PORT, 16'h001f);
    @(posedge mclk);
    unip <= 1'b0;
    fh <= 1'b1;
    settle;
    rd(OFS_AXIS_PORT, 16'h002f);
  endtask
  task automatic t_shared;
    wr(OFS_SHARED_DIR, 16'hff0c);
    wr(OFS_SHARED_DATA, 16'hffff);
    settle;
    chk({4'h0, sh_oe, sh_o}, 16'h0cf3);
    rd(OFS_SHARED_DATA, 16'h0037);
    rd(4'hf, 16'h0000);
    rd(OFS_AXIS_ENV, 16'h0000);
  endtask
  // reset in mid-run must undo the gpio function select, shared directions and general output written so far
  task automatic t_reset;
    wr(OFS_CTRL_MODE, 16'h0010);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    settle;
    chk({12'h0, ax_oe}, 16'h000f);
    chk({12'h0, ax_o}, {12'h0, ph});
    chk({10'h0, sh_oe}, 16'h0000);
    chk({15'h0, gen}, 16'h0000);
    rd(OFS_SHARED_DATA, 16'h0004);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    settle;
    t_phase;
    t_gen;
    t_axis;
    t_shared;
    t_reset;
    close_out;
  end
endmodule
